// >>> umnu_pkg.sv
// What this block does
// [RL1] Literal multiply: unsigned base times 5-bit literal, low word even register, high next.
// [RL2] Literal multiply decodes as 1011 1000 0, base, destination, 11, five literal bits.
// [RL3] Register multiply: unsigned base times unsigned source, 32-bit result across destination pair.
// [RL4] Multiply base and destination are register direct; source direct or indirect modes.
// [RL5] Software picks an even destination, never fourteen; stack pointer bit 0 stays zero.
// [RL6] Multiplies are word only, leave all flags alone, ignore the integer/fraction bit.
// [RL7] File negate writes inverse plus one of file register; address spans 0 to 8191.
// [RL8] File negate decodes 1110 1110 0, byte, destination, address; destination 0 means W0.
// [RL9] Byte-select 0 is word, 1 is byte; byte writes keep the other byte.
// [RL10] Register negate writes two's complement of source to destination, each with own mode.
// [RL11] Accumulator negate complements all 40 bits regardless of saturation setting.
// [RL12] Accumulator negate decodes 1100 1011, select bit, 001, then zeros.
// [RL13] Accumulator negate updates per-accumulator and combined overflow and saturation flags.
// [RL14] File and register negate set DC, N, OV, Z, C at byte or word width.
// [RL15] Each instruction is one word and one instruction cycle, address updates included.
package umnu_pkg;
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_SR = 8'h04;
  localparam logic [7:0] OFS_CORE_CONTROL_REGISTER = 8'h08;
  localparam logic [7:0] OFS_INT_STAT = 8'h0C;
  localparam logic [7:0] OFS_INT_MASK = 8'h10;
  localparam logic [7:0] OFS_MEM_ADDR = 8'h14;
  localparam logic [7:0] OFS_MEM_DATA = 8'h18;
  localparam logic [7:0] OFS_ACCUMULATOR_A_LO = 8'h1C;
  localparam logic [7:0] OFS_ACCUMULATOR_A_HI = 8'h20;
  localparam logic [7:0] OFS_ACCUMULATOR_B_LO = 8'h24;
  localparam logic [7:0] OFS_ACCUMULATOR_B_HI = 8'h28;
  localparam logic [1:0] OFS_DEFAULT_WORKING_REGISTER_PAGE = 2'h1;
  localparam int MEM_AW = 12;
  localparam logic [15:0] SR_RESET = 16'h0000;
  localparam logic [15:0] CORE_CONTROL_REGISTER_RESET = 16'h0000;
  localparam logic [15:0] DEFAULT_WORKING_REGISTER_RESET = 16'h0000;
  localparam logic [15:0] MEM_ADDR_RESET = 16'h0000;
  localparam logic [39:0] ACC_RESET = 40'h00_0000_0000;
  localparam logic [2:0] INT_RESET = 3'h0;
  localparam int SR_C = 0;
  localparam int SR_Z = 1;
  localparam int SR_OV = 2;
  localparam int SR_N = 3;
  localparam int SR_DC = 8;
  localparam int SR_SAB = 10;
  localparam int SR_OAB = 11;
  localparam int SR_SB = 12;
  localparam int SR_SA = 13;
  localparam int SR_OB = 14;
  localparam int SR_OA = 15;
  localparam int INT_DONE = 0;
  localparam int INT_ILLEGAL = 1;
  localparam int INT_ACC_OVF = 2;
  localparam logic [8:0] OPC_MUL = 9'h170;
  localparam logic [8:0] OPC_NEG_FILE = 9'h1DC;
  localparam logic [8:0] OPC_NEG_W = 9'h1D4;
  localparam logic [7:0] OPC_NEG_ACC = 8'hCB;
  localparam logic [2:0] NEG_ACC_TAG = 3'h1;
  localparam logic [1:0] LIT_TAG = 2'h3;
  localparam logic [2:0] AM_DIRECT = 3'h0;
  localparam logic [2:0] AM_POSTDEC = 3'h2;
  localparam logic [2:0] AM_POSTINC = 3'h3;
  localparam logic [2:0] AM_PREDEC = 3'h4;
  localparam logic [2:0] AM_PREINC = 3'h5;

  typedef enum logic [2:0] {
    OP_NONE, OP_MUL_LIT, OP_MUL_REG, OP_NEG_FILE, OP_NEG_W, OP_NEG_ACC
  } umnu_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_READ = 2'h1, ST_EXEC = 2'h3
  } umnu_state_t;

  typedef struct packed {
    umnu_op_t op;
    logic byte_mode;
    logic to_file;
    logic acc_b;
    logic [3:0] base;
    logic [3:0] dst;
    logic [2:0] dmode;
    logic [3:0] src;
    logic [2:0] smode;
    logic [4:0] lit;
    logic [12:0] faddr;
  } umnu_dec_t;

  function automatic umnu_dec_t umnu_decode(input logic [23:0] ins);
    umnu_dec_t d;
    d = '0;
    d.base = ins[14:11];
    d.dst = ins[10:7];
    d.dmode = ins[13:11];
    d.src = ins[3:0];
    d.smode = ins[6:4];
    d.lit = ins[4:0];
    d.faddr = ins[12:0];
    d.acc_b = ins[15];
    if (ins[23:15] == OPC_MUL) begin
      d.op = (ins[6:5] == LIT_TAG) ? OP_MUL_LIT : OP_MUL_REG;
    end else if (ins[23:15] == OPC_NEG_FILE) begin
      d.op = OP_NEG_FILE;
      d.byte_mode = ins[14];
      d.to_file = ins[13];
    end else if (ins[23:15] == OPC_NEG_W && ins[13:11] <= AM_PREINC && ins[6:4] <= AM_PREINC) begin
      d.op = OP_NEG_W;
      d.byte_mode = ins[14];
    end else if (ins[23:16] == OPC_NEG_ACC && ins[14:12] == NEG_ACC_TAG && ins[11:0] == 12'h000) begin
      d.op = OP_NEG_ACC;
    end
    return d;
  endfunction : umnu_decode

  function automatic logic [15:0] umnu_ea(input logic [15:0] v, input logic [2:0] m, input logic [15:0] s);
    if (m == AM_PREDEC) return 16'(v - s);
    if (m == AM_PREINC) return 16'(v + s);
    return v;
  endfunction : umnu_ea

  function automatic logic [15:0] umnu_post(input logic [15:0] v, input logic [2:0] m, input logic [15:0] s);
    if (m == AM_POSTDEC || m == AM_PREDEC) return 16'(v - s);
    if (m == AM_POSTINC || m == AM_PREINC) return 16'(v + s);
    return v;
  endfunction : umnu_post
endpackage : umnu_pkg

// >>> umnu_ram.sv
`timescale 1ns/1ps
module umnu_ram (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [1:0] be_i,
  input wire logic [umnu_pkg::MEM_AW-1:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o
);
  logic [15:0] mem [2**umnu_pkg::MEM_AW];

  // Read-first; read data always registered
  always_ff @(posedge clk_i) begin
    if (we_i && be_i[0]) begin
      mem[addr_i][7:0] <= wdata_i[7:0];
    end
    if (we_i && be_i[1]) begin
      mem[addr_i][15:8] <= wdata_i[15:8];
    end
    rdata_o <= mem[addr_i];
  end
endmodule : umnu_ram

// >>> umnu_core.sv
`timescale 1ns/1ps
module umnu_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  output logic busy_o
);
  logic [15:0] default_working_register [16];
  logic [15:0] next_default_working_register [16];
  logic [39:0] acc_a, next_acc_a, acc_b, next_acc_b, acc_sel, acc_neg;
  logic [15:0] sr, next_sr, core_control_register, next_core_control_register, mem_addr, next_mem_addr;
  logic [2:0] int_stat, next_int_stat, int_mask, next_int_mask, evt;
  umnu_pkg::umnu_state_t state, next_state;
  umnu_pkg::umnu_dec_t dec, next_dec;
  logic [12:0] sea, next_sea, dea, next_dea;
  logic [31:0] next_dat;
  logic next_ack;
  logic ram_we;
  logic [1:0] ram_be;
  logic [umnu_pkg::MEM_AW-1:0] ram_addr;
  logic [15:0] ram_wdata, ram_rdata;
  logic bus_req, wr_fire, idle, default_working_register_hit, ins_fire, from_mem, lane;
  logic [15:0] step, src_ea, dst_ea, word_in, neg_w, mul_b;
  logic [7:0] byte_in, neg_b;
  logic [31:0] prod;
  logic res_c, res_z, res_ov, res_n, res_dc, acc_ovf, acc_sat;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] be);
    return {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction : merge16

  assign bus_req = wb_cyc_i & wb_stb_i;
  // Writes land on the edge where the master sees ack
  assign wr_fire = bus_req & wb_we_i & wb_ack_o;
  assign idle = (state == umnu_pkg::ST_IDLE);
  assign busy_o = ~idle;
  assign default_working_register_hit = (wb_adr_i[7:6] == umnu_pkg::OFS_DEFAULT_WORKING_REGISTER_PAGE);
  assign ins_fire = wr_fire & idle & (wb_adr_i == umnu_pkg::OFS_INSTR);
  assign irq_o = |(int_stat & int_mask);

  // Operand path, shared by READ and EXEC
  assign step = dec.byte_mode ? 16'h0001 : 16'h0002;
  assign src_ea = umnu_pkg::umnu_ea(default_working_register[dec.src], dec.smode, step); // RL4 RL10
  assign dst_ea = umnu_pkg::umnu_ea(default_working_register[dec.dst], dec.dmode, step); // RL10
  assign from_mem = (dec.op == umnu_pkg::OP_NEG_FILE) || (dec.smode != umnu_pkg::AM_DIRECT);
  assign word_in = from_mem ? ram_rdata : default_working_register[dec.src];
  assign byte_in = (from_mem && sea[0]) ? word_in[15:8] : word_in[7:0];
  assign neg_w = 16'(~word_in + 16'h0001); // RL7 RL10
  assign neg_b = 8'(~byte_in + 8'h01); // RL9
  // Unsigned only; the integer/fraction bit is never consulted
  assign mul_b = (dec.op == umnu_pkg::OP_MUL_LIT) ? {11'h0, dec.lit} : word_in; // RL1 RL3 RL6
  assign prod = {16'h0000, default_working_register[dec.base]} * {16'h0000, mul_b}; // RL1 RL3
  assign acc_sel = dec.acc_b ? acc_b : acc_a;
  // Full 40 bits, no saturation applied
  assign acc_neg = 40'(~acc_sel + 40'h00_0000_0001); // RL11
  assign acc_ovf = ~((&acc_neg[39:31]) | ~(|acc_neg[39:31])); // RL13
  assign acc_sat = (acc_sel == 40'h80_0000_0000); // RL13

  // Byte vs word flags
  always_comb begin
    if (dec.byte_mode) begin // RL14
      res_n = neg_b[7];
      res_z = (neg_b == 8'h00);
      res_c = (byte_in == 8'h00);
      res_ov = (byte_in == 8'h80);
      res_dc = (byte_in[3:0] == 4'h0);
    end else begin
      res_n = neg_w[15];
      res_z = (neg_w == 16'h0000);
      res_c = (word_in == 16'h0000);
      res_ov = (word_in == 16'h8000);
      res_dc = (word_in[7:0] == 8'h00);
    end
  end

  // Memory port: engine owns it while busy
  always_comb begin
    ram_we = 1'b0;
    ram_be = 2'h3;
    ram_addr = mem_addr[12:1];
    ram_wdata = wb_dat_i[15:0];
    lane = (dec.op == umnu_pkg::OP_NEG_W) ? dea[0] : sea[0];
    if (state == umnu_pkg::ST_READ) begin
      ram_addr = (dec.op == umnu_pkg::OP_NEG_FILE) ? dec.faddr[12:1] : src_ea[12:1]; // RL7
    end else if (state == umnu_pkg::ST_EXEC) begin
      ram_addr = (dec.op == umnu_pkg::OP_NEG_W) ? dea[12:1] : sea[12:1];
      ram_we = (dec.op == umnu_pkg::OP_NEG_FILE && dec.to_file) || // RL8
               (dec.op == umnu_pkg::OP_NEG_W && dec.dmode != umnu_pkg::AM_DIRECT); // RL10
      ram_be = dec.byte_mode ? (lane ? 2'h2 : 2'h1) : 2'h3; // RL9
      ram_wdata = dec.byte_mode ? {neg_b, neg_b} : neg_w;
    end else if (wr_fire && wb_adr_i == umnu_pkg::OFS_MEM_DATA) begin
      ram_we = 1'b1;
      ram_be = wb_sel_i[1:0];
    end
  end

  umnu_ram u_ram (
    .clk_i(clk_i),
    .we_i(ram_we),
    .be_i(ram_be),
    .addr_i(ram_addr),
    .wdata_i(ram_wdata),
    .rdata_o(ram_rdata)
  );

  // Engine next state
  always_comb begin
    next_state = state;
    next_dec = dec;
    next_sea = sea;
    next_dea = dea;
    next_default_working_register = default_working_register;
    next_acc_a = acc_a;
    next_acc_b = acc_b;
    next_sr = sr;
    evt = 3'h0;
    unique case (state)
      umnu_pkg::ST_IDLE: begin
        if (ins_fire) begin
          next_dec = umnu_pkg::umnu_decode(wb_dat_i[23:0]); // RL2 RL3 RL8 RL12
          if (next_dec.op == umnu_pkg::OP_NONE) begin
            evt[umnu_pkg::INT_ILLEGAL] = 1'b1;
          end else begin
            next_state = umnu_pkg::ST_READ;
          end
        end else if (wr_fire && default_working_register_hit) begin
          next_default_working_register[wb_adr_i[5:2]] = merge16(default_working_register[wb_adr_i[5:2]], wb_dat_i[15:0], wb_sel_i[1:0]);
        end else if (wr_fire && wb_adr_i == umnu_pkg::OFS_SR) begin
          next_sr = merge16(sr, wb_dat_i[15:0], wb_sel_i[1:0]);
        end else if (wr_fire && wb_adr_i == umnu_pkg::OFS_ACCUMULATOR_A_LO) begin
          next_acc_a[15:0] = merge16(acc_a[15:0], wb_dat_i[15:0], wb_sel_i[1:0]);
          next_acc_a[31:16] = merge16(acc_a[31:16], wb_dat_i[31:16], wb_sel_i[3:2]);
        end else if (wr_fire && wb_adr_i == umnu_pkg::OFS_ACCUMULATOR_A_HI && wb_sel_i[0]) begin
          next_acc_a[39:32] = wb_dat_i[7:0];
        end else if (wr_fire && wb_adr_i == umnu_pkg::OFS_ACCUMULATOR_B_LO) begin
          next_acc_b[15:0] = merge16(acc_b[15:0], wb_dat_i[15:0], wb_sel_i[1:0]);
          next_acc_b[31:16] = merge16(acc_b[31:16], wb_dat_i[31:16], wb_sel_i[3:2]);
        end else if (wr_fire && wb_adr_i == umnu_pkg::OFS_ACCUMULATOR_B_HI && wb_sel_i[0]) begin
          next_acc_b[39:32] = wb_dat_i[7:0];
        end
      end
      umnu_pkg::ST_READ: begin
        next_sea = (dec.op == umnu_pkg::OP_NEG_FILE) ? dec.faddr : src_ea[12:0]; // RL7
        next_dea = dst_ea[12:0];
        next_state = umnu_pkg::ST_EXEC; // RL15
      end
      umnu_pkg::ST_EXEC: begin
        next_state = umnu_pkg::ST_IDLE; // RL15
        evt[umnu_pkg::INT_DONE] = 1'b1;
        if (dec.op == umnu_pkg::OP_MUL_REG || dec.op == umnu_pkg::OP_NEG_W) begin
          next_default_working_register[dec.src] = umnu_pkg::umnu_post(default_working_register[dec.src], dec.smode, step); // RL4 RL15
        end
        if (dec.op == umnu_pkg::OP_NEG_W) begin
          next_default_working_register[dec.dst] = umnu_pkg::umnu_post(default_working_register[dec.dst], dec.dmode, step); // RL10
        end
        if (dec.op == umnu_pkg::OP_MUL_LIT || dec.op == umnu_pkg::OP_MUL_REG) begin
          next_default_working_register[dec.dst] = prod[15:0]; // RL1 RL3
          next_default_working_register[4'(dec.dst + 4'h1)] = prod[31:16];
        end
        if ((dec.op == umnu_pkg::OP_NEG_W && dec.dmode == umnu_pkg::AM_DIRECT) ||
            (dec.op == umnu_pkg::OP_NEG_FILE && !dec.to_file)) begin
          if (dec.op == umnu_pkg::OP_NEG_W) begin
            next_default_working_register[dec.dst] = dec.byte_mode ? {default_working_register[dec.dst][15:8], neg_b} : neg_w; // RL9 RL10
          end else begin
            next_default_working_register[0] = dec.byte_mode ? {default_working_register[0][15:8], neg_b} : neg_w; // RL8 RL9
          end
        end
        if (dec.op == umnu_pkg::OP_NEG_FILE || dec.op == umnu_pkg::OP_NEG_W) begin
          next_sr[umnu_pkg::SR_C] = res_c; // RL14
          next_sr[umnu_pkg::SR_Z] = res_z;
          next_sr[umnu_pkg::SR_OV] = res_ov;
          next_sr[umnu_pkg::SR_N] = res_n;
          next_sr[umnu_pkg::SR_DC] = res_dc;
        end
        if (dec.op == umnu_pkg::OP_NEG_ACC) begin
          if (dec.acc_b) begin
            next_acc_b = acc_neg; // RL11
            next_sr[umnu_pkg::SR_OB] = acc_ovf; // RL13
            next_sr[umnu_pkg::SR_SB] = sr[umnu_pkg::SR_SB] | acc_sat;
          end else begin
            next_acc_a = acc_neg; // RL11
            next_sr[umnu_pkg::SR_OA] = acc_ovf; // RL13
            next_sr[umnu_pkg::SR_SA] = sr[umnu_pkg::SR_SA] | acc_sat;
          end
          next_sr[umnu_pkg::SR_OAB] = next_sr[umnu_pkg::SR_OA] | next_sr[umnu_pkg::SR_OB]; // RL13
          next_sr[umnu_pkg::SR_SAB] = next_sr[umnu_pkg::SR_SA] | next_sr[umnu_pkg::SR_SB];
          evt[umnu_pkg::INT_ACC_OVF] = acc_ovf | acc_sat;
        end
      end
      default: begin
        next_state = umnu_pkg::ST_IDLE;
      end
    endcase
    // Stack pointer stays word aligned, so a W14 pair loses bit 16
    next_default_working_register[15][0] = 1'b0; // RL5
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= umnu_pkg::ST_IDLE;
      dec <= '0;
      sea <= 13'h0;
      dea <= 13'h0;
      for (int i = 0; i < 16; i++) begin
        default_working_register[i] <= umnu_pkg::DEFAULT_WORKING_REGISTER_RESET;
      end
      acc_a <= umnu_pkg::ACC_RESET;
      acc_b <= umnu_pkg::ACC_RESET;
      sr <= umnu_pkg::SR_RESET;
    end else begin
      state <= next_state;
      dec <= next_dec;
      sea <= next_sea;
      dea <= next_dea;
      default_working_register <= next_default_working_register;
      acc_a <= next_acc_a;
      acc_b <= next_acc_b;
      sr <= next_sr;
    end
  end

  // Bus side: config, interrupts, read data
  always_comb begin
    next_ack = bus_req & ~wb_ack_o;
    next_dat = wb_dat_o;
    next_core_control_register = core_control_register;
    next_mem_addr = mem_addr;
    next_int_mask = int_mask;
    next_int_stat = int_stat;
    if (wr_fire && wb_adr_i == umnu_pkg::OFS_CORE_CONTROL_REGISTER) begin
      next_core_control_register = merge16(core_control_register, wb_dat_i[15:0], wb_sel_i[1:0]);
    end
    if (wr_fire && wb_adr_i == umnu_pkg::OFS_MEM_ADDR) begin
      next_mem_addr = merge16(mem_addr, wb_dat_i[15:0], wb_sel_i[1:0]);
    end
    if (wr_fire && wb_adr_i == umnu_pkg::OFS_INT_MASK && wb_sel_i[0]) begin
      next_int_mask = wb_dat_i[2:0];
    end
    if (wr_fire && wb_adr_i == umnu_pkg::OFS_INT_STAT && wb_sel_i[0]) begin
      next_int_stat = int_stat & ~wb_dat_i[2:0];
    end
    // Set beats clear in the same cycle
    next_int_stat = next_int_stat | evt;
    if (bus_req && !wb_ack_o) begin
      next_dat = 32'h0000_0000;
      if (default_working_register_hit) begin
        next_dat = {16'h0000, default_working_register[wb_adr_i[5:2]]};
      end else begin
        case (wb_adr_i)
          umnu_pkg::OFS_INSTR: next_dat = {31'h0, busy_o};
          umnu_pkg::OFS_SR: next_dat = {16'h0000, sr};
          umnu_pkg::OFS_CORE_CONTROL_REGISTER: next_dat = {16'h0000, core_control_register};
          umnu_pkg::OFS_INT_STAT: next_dat = {29'h0, int_stat};
          umnu_pkg::OFS_INT_MASK: next_dat = {29'h0, int_mask};
          umnu_pkg::OFS_MEM_ADDR: next_dat = {16'h0000, mem_addr};
          umnu_pkg::OFS_MEM_DATA: next_dat = {16'h0000, ram_rdata};
          umnu_pkg::OFS_ACCUMULATOR_A_LO: next_dat = acc_a[31:0];
          umnu_pkg::OFS_ACCUMULATOR_A_HI: next_dat = {24'h00_0000, acc_a[39:32]};
          umnu_pkg::OFS_ACCUMULATOR_B_LO: next_dat = acc_b[31:0];
          umnu_pkg::OFS_ACCUMULATOR_B_HI: next_dat = {24'h00_0000, acc_b[39:32]};
          default: next_dat = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      core_control_register <= umnu_pkg::CORE_CONTROL_REGISTER_RESET;
      mem_addr <= umnu_pkg::MEM_ADDR_RESET;
      int_mask <= umnu_pkg::INT_RESET;
      int_stat <= umnu_pkg::INT_RESET;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
      core_control_register <= next_core_control_register;
      mem_addr <= next_mem_addr;
      int_mask <= next_int_mask;
      int_stat <= next_int_stat;
    end
  end

  logic exec_now;
  logic [31:0] mul_chk;
  assign exec_now = (state == umnu_pkg::ST_EXEC);
  assign mul_chk = {16'h0000, default_working_register[dec.base]} * {27'h0, dec.lit};

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_mul_lit;
    (exec_now && dec.op == umnu_pkg::OP_MUL_LIT && dec.dst[0] == 1'b0 && dec.dst != 4'hE)
      |=> {default_working_register[$past(dec.dst) + 4'h1], default_working_register[$past(dec.dst)]} == $past(mul_chk);
  endproperty
  a_mul_lit: assert property (p_mul_lit) else $error("literal multiply pair wrong"); // RL1
  property p_dec_lit;
    (ins_fire && wb_dat_i[23:15] == umnu_pkg::OPC_MUL && wb_dat_i[6:5] == umnu_pkg::LIT_TAG)
      |=> state == umnu_pkg::ST_READ && dec.op == umnu_pkg::OP_MUL_LIT;
  endproperty
  a_dec_lit: assert property (p_dec_lit) else $error("literal multiply not decoded"); // RL2
  property p_dec_reg;
    (ins_fire && wb_dat_i[23:15] == umnu_pkg::OPC_MUL && wb_dat_i[6:5] != umnu_pkg::LIT_TAG)
      |=> dec.op == umnu_pkg::OP_MUL_REG ##1 state == umnu_pkg::ST_EXEC;
  endproperty
  a_dec_reg: assert property (p_dec_reg) else $error("register multiply not decoded"); // RL3
  property p_post_inc;
    (exec_now && dec.op == umnu_pkg::OP_MUL_REG && dec.smode == umnu_pkg::AM_POSTINC &&
     dec.src != dec.dst && dec.src != 4'(dec.dst + 4'h1) && dec.src != 4'hF)
      |=> default_working_register[$past(dec.src)] == 16'($past(default_working_register[dec.src]) + 16'h0002);
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("source post-increment missing"); // RL4
  property p_sp_even;
    !idle |-> ##1 (default_working_register[15][0] == 1'b0)[*2];
  endproperty
  a_sp_even: assert property (p_sp_even) else $error("stack pointer bit 0 set"); // RL5
  property p_mul_flags;
    (exec_now && (dec.op == umnu_pkg::OP_MUL_LIT || dec.op == umnu_pkg::OP_MUL_REG)) |=> $stable(sr);
  endproperty
  a_mul_flags: assert property (p_mul_flags) else $error("multiply touched status"); // RL6
  property p_file_addr;
    (state == umnu_pkg::ST_READ && dec.op == umnu_pkg::OP_NEG_FILE) |-> ram_addr == dec.faddr[12:1];
  endproperty
  a_file_addr: assert property (p_file_addr) else $error("file address not used"); // RL7
  property p_neg_default_working_register;
    (exec_now && dec.op == umnu_pkg::OP_NEG_FILE && !dec.to_file && !dec.byte_mode)
      |=> default_working_register[0] == 16'(~$past(ram_rdata) + 16'h0001);
  endproperty
  a_neg_default_working_register: assert property (p_neg_default_working_register) else $error("file negate to W0 wrong"); // RL8
  property p_byte_keep;
    (exec_now && dec.op == umnu_pkg::OP_NEG_W && dec.byte_mode && dec.dmode == umnu_pkg::AM_DIRECT &&
     dec.smode == umnu_pkg::AM_DIRECT && dec.dst != 4'hF)
      |=> default_working_register[$past(dec.dst)][15:8] == $past(default_working_register[dec.dst][15:8]);
  endproperty
  a_byte_keep: assert property (p_byte_keep) else $error("byte negate changed upper byte"); // RL9
  property p_acc_neg;
    (exec_now && dec.op == umnu_pkg::OP_NEG_ACC && !dec.acc_b) |=> acc_a == 40'(~$past(acc_a) + 40'h00_0000_0001);
  endproperty
  a_acc_neg: assert property (p_acc_neg) else $error("accumulator A negate wrong"); // RL11
  property p_acc_flags;
    (exec_now && dec.op == umnu_pkg::OP_NEG_ACC)
      |=> sr[umnu_pkg::SR_OAB] == (sr[umnu_pkg::SR_OA] | sr[umnu_pkg::SR_OB]) &&
          sr[umnu_pkg::SR_SAB] == (sr[umnu_pkg::SR_SA] | sr[umnu_pkg::SR_SB]);
  endproperty
  a_acc_flags: assert property (p_acc_flags) else $error("combined flags inconsistent"); // RL13
  property p_neg_flags;
    (exec_now && dec.op == umnu_pkg::OP_NEG_W && !dec.byte_mode)
      |=> sr[umnu_pkg::SR_OV] == ($past(word_in) == 16'h8000) && sr[umnu_pkg::SR_C] == ($past(word_in) == 16'h0000);
  endproperty
  a_neg_flags: assert property (p_neg_flags) else $error("negate flags wrong"); // RL14
  property p_one_cycle;
    ins_fire && wb_dat_i[23:16] == umnu_pkg::OPC_NEG_ACC && wb_dat_i[14:12] == umnu_pkg::NEG_ACC_TAG &&
      wb_dat_i[11:0] == 12'h000 |=> state == umnu_pkg::ST_READ ##1 exec_now ##1 idle;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("instruction took wrong time"); // RL12 RL15
endmodule : umnu_core

// >>> umnu_core_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module umnu_core_bench;
  typedef struct {
    logic [23:0] ins;
    logic [15:0] ma, md;
    logic [3:0] ra;
    logic [15:0] va;
    logic [3:0] rb;
    logic [15:0] vb;
    logic [3:0] rc;
    logic [31:0] ex;
    logic [15:0] sr;
  } umnu_row_t;
  logic clk_i, rst_i, cyc, stb, we, ack, irq, busy;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  int err_total, check_count;
  // Status preset to 000F so untouched flags show; multiply destinations even, never fourteen
  umnu_row_t rows [8] = '{
    '{24'hB8387F, 16'h0, 16'h0, 4'd7, 16'hF240, 4'd1, 16'h0, 4'd0, 32'h001D55C0, 16'h000F},
    '{24'hB82100, 16'h0, 16'h0, 4'd4, 16'hFFFF, 4'd0, 16'hFFFF, 4'd2, 32'hFFFE0001, 16'h000F},
    '{24'hEA0283, 16'h0, 16'h0, 4'd3, 16'h0001, 4'd6, 16'h1234, 4'd5, 32'h1234FFFF, 16'h0008},
    '{24'hEA4283, 16'h0, 16'h0, 4'd3, 16'h7839, 4'd5, 16'hAAAA, 4'd5, 32'h1234AAC7, 16'h0008},
    '{24'hEA0283, 16'h0, 16'h0, 4'd3, 16'h0000, 4'd6, 16'h1234, 4'd5, 32'h12340000, 16'h0103},
    '{24'hEA0283, 16'h0, 16'h0, 4'd3, 16'h8000, 4'd6, 16'h1234, 4'd5, 32'h12348000, 16'h010C},
    '{24'hB80231, 16'h0300, 16'hD625, 4'd0, 16'h1024, 4'd1, 16'h0300, 4'd4, 32'h0D806D34, 16'h000F},
    '{24'hEE4880, 16'h0880, 16'h2355, 4'd0, 16'h9080, 4'd1, 16'h0000, 4'd0, 32'h000090AB, 16'h0008}
  };
  umnu_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .busy_o(busy));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  function automatic logic [7:0] wa(input logic [3:0] n);
    return {2'b01, n, 2'b00};
  endfunction : wa
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (i = 0; i < 40; i++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (i == 40) begin
      err_total++;
      finish_test();
    end
  endtask : bus
  task automatic exe(input logic [23:0] ins);
    int i;
    bus(1'b1, umnu_pkg::OFS_INSTR, {8'h00, ins});
    for (i = 0; i < 40; i++) begin
      @(posedge clk_i);
      #1;
      if (busy === 1'b0) break;
    end
    if (i == 40) begin
      err_total++;
      finish_test();
    end
  endtask : exe
  initial begin
    {cyc, stb, we, adr, wdat} = '0;
    sel = 4'hF;
    rst_i = 1'b1;
    err_total = 0;
    check_count = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, umnu_pkg::OFS_SR, 32'h0);
    `CHK(q[15:0], umnu_pkg::SR_RESET)
    // Integer/fraction bit set on purpose; products must ignore it
    bus(1'b1, umnu_pkg::OFS_CORE_CONTROL_REGISTER, 32'h1);
    foreach (rows[k]) begin
      bus(1'b1, umnu_pkg::OFS_MEM_ADDR, 32'(rows[k].ma));
      bus(1'b1, umnu_pkg::OFS_MEM_DATA, 32'(rows[k].md));
      bus(1'b1, wa(rows[k].ra), 32'(rows[k].va));
      bus(1'b1, wa(rows[k].rb), 32'(rows[k].vb));
      bus(1'b1, umnu_pkg::OFS_SR, 32'h000F);
      exe(rows[k].ins);
      bus(1'b0, wa(rows[k].rc), 32'h0);
      `CHK(q[15:0], rows[k].ex[15:0])
      bus(1'b0, wa(4'(rows[k].rc + 4'd1)), 32'h0);
      `CHK(q[15:0], rows[k].ex[31:16])
      bus(1'b0, umnu_pkg::OFS_SR, 32'h0);
      `CHK(q[15:0], rows[k].sr)
      $display("row %0d done", k);
    end
    bus(1'b1, umnu_pkg::OFS_ACCUMULATOR_B_LO, 32'hF23010DC);
    bus(1'b1, umnu_pkg::OFS_ACCUMULATOR_B_HI, 32'hFF);
    bus(1'b1, umnu_pkg::OFS_CORE_CONTROL_REGISTER, 32'h00C0);
    exe(24'hCB9000);
    bus(1'b0, umnu_pkg::OFS_ACCUMULATOR_B_LO, 32'h0);
    `CHK(q, 32'h0DCFEF24)
    bus(1'b0, umnu_pkg::OFS_ACCUMULATOR_B_HI, 32'h0);
    `CHK(q[7:0], 8'h00)
    bus(1'b1, umnu_pkg::OFS_SR, 32'h0);
    bus(1'b1, umnu_pkg::OFS_ACCUMULATOR_A_HI, 32'h80);
    exe(24'hCB1000);
    bus(1'b0, umnu_pkg::OFS_SR, 32'h0);
    `CHK(q[15:0], 16'hAC00)
    $display("accumulator test done");
    bus(1'b1, umnu_pkg::OFS_INT_STAT, 32'h7);
    bus(1'b1, umnu_pkg::OFS_INT_MASK, 32'h2);
    exe(24'h000000);
    `CHK(irq, 1'b1)
    bus(1'b1, umnu_pkg::OFS_INT_STAT, 32'h2);
    @(posedge clk_i);
    #1;
    `CHK(irq, 1'b0)
    bus(1'b0, 8'h3C, 32'h0);
    `CHK(q, 32'h0)
    $display("interrupt and map test done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, wa(4'd0), 32'h0);
    `CHK(q[15:0], umnu_pkg::DEFAULT_WORKING_REGISTER_RESET)
    bus(1'b0, umnu_pkg::OFS_ACCUMULATOR_A_HI, 32'h0);
    `CHK(q[7:0], umnu_pkg::ACC_RESET[39:32])
    `CHK(irq, 1'b0)
    $display("mid-run reset test done");
    finish_test();
  end
endmodule : umnu_core_bench
